// ==== rtl/bsc_pkg.sv ====
// Package: boundary-scan cell layout and fixed values
package bsc_pkg;

  // ==========================================================
  // Per-pin cell group, three cells for each port pin
  // ==========================================================
  localparam int PIN_CELLS = 3;
  localparam int PIN_PU    = 0;  // Pull-up enable cell
  localparam int PIN_OC    = 1;  // Output control stage
  localparam int PIN_OD    = 2;  // Output / input data stage

  // ==========================================================
  // Fixed cells, offsets above the last pin group
  // ==========================================================
  localparam int OFS_TW      = 0;   // Two cells, clock then data
  localparam int TW_N        = 2;
  localparam int OFS_RST_LV  = 2;   // Low-voltage reset observe
  localparam int OFS_RST_HV  = 3;   // High-voltage reset observe
  localparam int OFS_OSC_EN  = 4;   // Five oscillator enables
  localparam int OFS_OSC_CK  = 9;   // Five observed clock lines
  localparam int OFS_CMP_OFF = 14;
  localparam int OFS_CMP_MUX = 15;
  localparam int OFS_CMP_BG  = 16;
  localparam int OFS_CMP_OUT = 17;
  localparam int FIX_CELLS   = 18;

  // ==========================================================
  // Oscillator vector bit positions
  // ==========================================================
  localparam int OSC_N        = 5;
  localparam int OSC_EXT_CLK  = 0;  // ext_clock_input_enable
  localparam int OSC_CRYSTAL  = 1;  // crystal_osc_enable
  localparam int OSC_EXT_RC   = 2;  // ext_rc_osc_enable
  localparam int OSC_LOWFREQ  = 3;  // lowfreq_crystal_enable
  localparam int OSC_TIMER    = 4;  // timer_osc_enable

  // Level read on a clock line whose option is unused
  localparam logic [OSC_N-1:0] OSC_IDLE_LEVEL = 5'h04;

  // ==========================================================
  // Reset values of the functional outputs
  // ==========================================================
  localparam logic CMP_OFF_RST = 1'h1;  // Comparator off
  localparam logic CMP_SEL_RST = 1'h0;
  localparam logic PIN_RST     = 1'h0;  // Pins released

endpackage

// ==== rtl/bsc_scan_if.sv ====
// Interface: scan strobes and parallel data of one scan register
`timescale 1ns/1ps
interface bsc_scan_if #(
  parameter int W = 8
);
  logic         capture;   // Capture-DR strobe
  logic         shift;     // Shift-DR strobe
  logic         update;    // Update-DR strobe
  logic         tdi;       // Serial in
  logic         tdo;       // Serial out, from a flop
  logic [W-1:0] cap_data;  // Parallel capture values
  logic [W-1:0] upd_data;  // Update latches

  modport chain (
    input  capture, shift, update, tdi, cap_data,
    output tdo, upd_data
  );
  modport ctrl (
    output capture, shift, update, tdi, cap_data,
    input  tdo, upd_data
  );
endinterface

// ==== rtl/bsc_sync.sv ====
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module bsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,     // Destination clock
  input  wire logic         resetn_i,  // Async reset, low
  input  wire logic [W-1:0] d_i,       // Foreign level
  output logic      [W-1:0] q_o        // Synchronised level
);
  logic [W-1:0] meta;

  // ==========================================================
  // Stages run freely so a frozen block never holds meta
  // ==========================================================
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ==== rtl/bsc_chain.sv ====
// Scan register with capture, LSB-first shift and update latches
`timescale 1ns/1ps
module bsc_chain #(
  parameter int W = 8
) (
  input  wire logic tck_i,      // Link clock
  input  wire logic resetn_i,   // Async reset, low
  bsc_scan_if.chain sif         // Strobes and data
);
  logic [W-1:0] sh;

  // ==========================================================
  // Shift stages: capture wins over shift if both are given
  // ==========================================================
  always_ff @(posedge tck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh <= '0;
    end else if (sif.capture) begin
      sh <= sif.cap_data;
    end else if (sif.shift) begin
      sh <= {sif.tdi, sh[W-1:1]};  // see RULE_21
    end
  end

  // Update latches hold still while shifting goes on
  always_ff @(posedge tck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sif.upd_data <= '0;
    end else if (sif.update) begin
      sif.upd_data <= sh;  // see RULE_23
    end
  end

  assign sif.tdo = sh[0];  // see RULE_21
endmodule

// ==== rtl/bsc_top.sv ====
// Boundary-scan cells for port pins, clocks, reset and comparator
// Function
// RULE_01: Separate pull-up enable cell per port pin
// RULE_02: Pin cell folds three signals into two
// RULE_03: No alternate: data, latch, direction map directly
// RULE_04: Pull-up enable is ~global ~dir and latch
// RULE_05: Alternate functions join core side of cells
// RULE_06: Analog pins bypass; cells on control interface
// RULE_07: Extra cell per two-wire buffer enable
// RULE_08: No cell for two-wire spike filter
// RULE_09: Tester never enables control and two-wire both
// RULE_10: Reset pin has two observe-only cells
// RULE_11: Oscillator enable cell plus clock observe cell
// RULE_12: Internal RC oscillator stays out of chain
// RULE_13: Unused clock lines read fixed levels
// RULE_14: Tester enables one main clock source only
// RULE_15: Internal capacitor fuse not scan controllable
// RULE_16: Tester prefers observing external clock input
// RULE_17: Every comparator signal has a general cell
// RULE_18: Comparator off high switches comparator off
// RULE_19: Mux select and bandgap enable when high
// RULE_20: Comparator output captured as observed cell
// RULE_21: All scan registers shift LSB first
// RULE_22: External test captures, shifts, drives at update
// RULE_23: Preload loads latches, pins unaffected
// RULE_24: External test drives data when control set
// RULE_25: External test overrides functional controls
`timescale 1ns/1ps
module bsc_top
  import bsc_pkg::*;
#(
  parameter int NPIN    = 8,  // Bidirectional port pins
  parameter int SCL_PIN = 0,  // Two-wire clock pin index
  parameter int SDA_PIN = 1   // Two-wire data pin index
) (
  // Core clock domain
  input  wire logic             mclk_i,        // Core clock
  input  wire logic             resetn_i,      // Async reset
  input  wire logic             ce_i,          // Core enable
  input  wire logic [NPIN-1:0]  port_output_latch_i, // Latch
  input  wire logic [NPIN-1:0]  direction_bit_i,  // 1 = out
  input  wire logic             pullup_disable_global_i,
  input  wire logic [NPIN-1:0]  alt_en_i,      // Alt owns pin
  input  wire logic [NPIN-1:0]  alt_out_i,     // Alt data
  input  wire logic [NPIN-1:0]  alt_oe_i,      // Alt enable
  input  wire logic [NPIN-1:0]  pad_i,         // Pin levels
  output logic      [NPIN-1:0]  pad_o,         // Pin drive
  output logic      [NPIN-1:0]  pad_oe_o,      // Drive enable
  output logic      [NPIN-1:0]  pullup_en_o,   // Pull-ups
  output logic      [NPIN-1:0]  pin_input_value_o, // Synced
  input  wire logic [TW_N-1:0]  twowire_buffer_enable_i,
  output logic      [TW_N-1:0]  twowire_drive_en_o, // Slew
  input  wire logic             reset_pin_i,   // Low = reset
  input  wire logic             hv_reset_i,    // HV detected
  input  wire logic [OSC_N-1:0] osc_enable_i,  // From clocks
  input  wire logic [OSC_N-1:0] osc_clock_i,   // Clock lines
  output logic      [OSC_N-1:0] osc_enable_o,  // To clocks
  input  wire logic             internal_cap_fuse_i,
  output logic                  internal_cap_o, // Caps on
  input  wire logic             comparator_off_i,
  input  wire logic             comparator_mux_select_i,
  input  wire logic             comparator_bandgap_enable_i,
  input  wire logic             comparator_out_i, // Analog
  output logic                  comparator_off_o,
  output logic                  comparator_mux_select_o,
  output logic                  comparator_bandgap_enable_o,
  // Link clock domain, from the test access port
  input  wire logic             tck_i,         // Test clock
  input  wire logic             tdi_i,         // Serial in
  input  wire logic             tap_capture_i, // Capture-DR
  input  wire logic             tap_shift_i,   // Shift-DR
  input  wire logic             tap_update_i,  // Update-DR
  input  wire logic             extest_i,      // Ext test on
  input  wire logic             instr_a_i,     // Preload on
  output logic                  tdo_o          // Serial out
);
  localparam int FB = PIN_CELLS * NPIN;  // First fixed cell
  localparam int CL = FB + FIX_CELLS;    // Chain length

  // ==========================================================
  // Scan register, link clock domain
  // ==========================================================
  bsc_scan_if #(.W(CL)) sif ();

  logic          chain_sel;
  logic [CL-1:0] cap_raw;    // Values seen at capture
  logic [CL-1:0] cap_sync;   // Same, two flops on tck
  logic [CL-1:0] cap_obs;    // Chain capture word
  logic          upd_tgl;    // Flips at every update

  // Chain answers to both test and preload instructions
  assign chain_sel    = extest_i | instr_a_i;
  assign sif.capture  = tap_capture_i & chain_sel; // see RULE_22
  assign sif.shift    = tap_shift_i & chain_sel;
  assign sif.update   = tap_update_i & chain_sel;  // see RULE_23
  assign sif.tdi      = tdi_i;
  assign sif.cap_data = cap_obs;
  assign tdo_o        = sif.tdo;  // Flop inside the chain

  bsc_chain #(.W(CL)) u_chain (
    .tck_i    (tck_i),
    .resetn_i (resetn_i),
    .sif      (sif)
  );

  // Pins and core levels are foreign to tck
  bsc_sync #(.W(CL)) u_cap_sync (
    .clk_i    (tck_i),
    .resetn_i (resetn_i),
    .d_i      (cap_raw),
    .q_o      (cap_sync)
  );

  // Toggle carries the update event; latches stay put after it
  always_ff @(posedge tck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      upd_tgl <= 1'h0;
    end else if (sif.update) begin
      upd_tgl <= ~upd_tgl;
    end
  end

  // ==========================================================
  // Crossing into the core clock domain
  // ==========================================================
  logic          ext_m;     // External test, synced
  logic          tgl_s;     // Update toggle, synced
  logic          tgl_d;     // Last toggle seen
  logic          upd_new;
  logic [CL-1:0] upd_m;     // Core copy of update latches

  bsc_sync #(.W(1)) u_ext_sync (
    .clk_i    (mclk_i),
    .resetn_i (resetn_i),
    .d_i      (extest_i),
    .q_o      (ext_m)
  );

  bsc_sync #(.W(1)) u_tgl_sync (
    .clk_i    (mclk_i),
    .resetn_i (resetn_i),
    .d_i      (upd_tgl),
    .q_o      (tgl_s)
  );

  bsc_sync #(.W(NPIN)) u_pin_sync (
    .clk_i    (mclk_i),
    .resetn_i (resetn_i),
    .d_i      (pad_i),
    .q_o      (pin_input_value_o)  // see RULE_03
  );

  // Level compare, so a frozen core still sees the event later
  assign upd_new = tgl_s ^ tgl_d;

  // Latches are copied whatever the mode, so test entry drives
  // the preloaded values at once
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgl_d <= 1'h0;
      upd_m <= '0;
    end else if (ce_i && upd_new) begin
      tgl_d <= tgl_s;
      upd_m <= sif.upd_data;  // see RULE_22
    end
  end

  // ==========================================================
  // Port pins: functional values and chain mapping
  // ==========================================================
  logic [NPIN-1:0] f_pu;      // Functional pull-up enable
  logic [NPIN-1:0] f_oc;      // Functional output control
  logic [NPIN-1:0] f_od;      // Functional output data
  logic [NPIN-1:0] next_pad;
  logic [NPIN-1:0] next_oe;
  logic [NPIN-1:0] next_pu;

  // Alternate functions are muxed before the cells, so the
  // data stage always samples the real pin level
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    localparam int B = PIN_CELLS * p;
    assign f_pu[p] = ~pullup_disable_global_i
                   & ~direction_bit_i[p]
                   & port_output_latch_i[p];  // see RULE_04
    assign f_oc[p] = alt_en_i[p] ? alt_oe_i[p]
                   : direction_bit_i[p];      // see RULE_05
    assign f_od[p] = alt_en_i[p] ? alt_out_i[p]
                   : port_output_latch_i[p];  // see RULE_03
    // Own pull-up cell, then a two-stage pin cell
    assign cap_raw[B+PIN_PU] = f_pu[p];       // see RULE_01
    assign cap_raw[B+PIN_OC] = f_oc[p];       // see RULE_02
    assign cap_raw[B+PIN_OD] = pad_i[p];      // see RULE_02
    assign next_oe[p]  = ext_m ? upd_m[B+PIN_OC]
                       : f_oc[p];             // see RULE_24
    assign next_pad[p] = ext_m ? upd_m[B+PIN_OD]
                       : f_od[p];             // see RULE_24
    assign next_pu[p]  = ext_m ? upd_m[B+PIN_PU]
                       : f_pu[p];             // see RULE_25
  end

  // ==========================================================
  // Two-wire buffer enables, reset, clocks, comparator
  // ==========================================================
  logic [TW_N-1:0]  next_tw;
  logic [OSC_N-1:0] next_osc;
  logic [OSC_N-1:0] osc_line;  // Observed clock lines
  logic [OSC_N-1:0] osc_en_t;  // Enables on tck
  logic             next_cmp_off;
  logic             next_cmp_mux;
  logic             next_cmp_bg;

  // No spike filter cell, pin cells cover it; see RULE_08
  assign cap_raw[FB+OFS_TW +: TW_N] =
         twowire_buffer_enable_i;             // see RULE_07
  assign next_tw = ext_m ? upd_m[FB+OFS_TW +: TW_N]
                 : twowire_buffer_enable_i;   // see RULE_25

  // Reset pin observed twice, never driven
  assign cap_raw[FB+OFS_RST_LV] = reset_pin_i; // see RULE_10
  assign cap_raw[FB+OFS_RST_HV] = hv_reset_i;  // see RULE_10

  // Sync enables so the idle mux never sees raw clocks
  bsc_sync #(.W(OSC_N)) u_osc_sync (
    .clk_i    (tck_i),
    .resetn_i (resetn_i),
    .d_i      (osc_enable_o),
    .q_o      (osc_en_t)
  );

  // Unused options read a fixed level instead of a stale line;
  // internal RC clock has no pin, no cell; see RULE_12
  assign osc_line = (osc_en_t & cap_sync[FB+OFS_OSC_CK +: OSC_N])
                  | (~osc_en_t & OSC_IDLE_LEVEL); // see RULE_13
  assign cap_raw[FB+OFS_OSC_EN +: OSC_N] =
         osc_enable_i;                        // see RULE_11
  assign cap_raw[FB+OFS_OSC_CK +: OSC_N] =
         osc_clock_i;                         // see RULE_11
  assign cap_obs = {cap_sync[CL-1:FB+OFS_CMP_OFF], osc_line,
                    cap_sync[FB+OFS_OSC_CK-1:0]};
  assign next_osc = ext_m ? upd_m[FB+OFS_OSC_EN +: OSC_N]
                  : osc_enable_i;             // see RULE_25

  // Analog pins go straight to the comparator; only its
  // digital controls and output are scanned; see RULE_06
  assign cap_raw[FB+OFS_CMP_OFF] = comparator_off_i;
  assign cap_raw[FB+OFS_CMP_MUX] = comparator_mux_select_i;
  assign cap_raw[FB+OFS_CMP_BG]  =
         comparator_bandgap_enable_i;         // see RULE_17
  assign cap_raw[FB+OFS_CMP_OUT] =
         comparator_out_i;                    // see RULE_20
  assign next_cmp_off = ext_m ? upd_m[FB+OFS_CMP_OFF]
                      : comparator_off_i;     // see RULE_18
  assign next_cmp_mux = ext_m ? upd_m[FB+OFS_CMP_MUX]
                      : comparator_mux_select_i; // see RULE_19
  assign next_cmp_bg  = ext_m ? upd_m[FB+OFS_CMP_BG]
                      : comparator_bandgap_enable_i; // see RULE_19

  // ==========================================================
  // Output flops, core clock domain
  // ==========================================================
  // Pins drive only while their control is set; the two-wire
  // enable is passed as loaded, so contention stays the
  // tester's to avoid (see RULE_09)
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_o       <= {NPIN{PIN_RST}};
      pad_oe_o    <= {NPIN{PIN_RST}};
      pullup_en_o <= {NPIN{PIN_RST}};
    end else if (ce_i) begin
      pad_o       <= next_pad;
      pad_oe_o    <= next_oe;   // see RULE_24
      pullup_en_o <= next_pu;
    end
  end

  // Fuse is copied straight through, the chain cannot reach it
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      twowire_drive_en_o <= {TW_N{PIN_RST}};
      osc_enable_o       <= {OSC_N{PIN_RST}};
      internal_cap_o     <= PIN_RST;
    end else if (ce_i) begin
      twowire_drive_en_o <= next_tw;
      osc_enable_o       <= next_osc;
      internal_cap_o     <= internal_cap_fuse_i; // see RULE_15
    end
  end

  // Comparator starts switched off until told otherwise
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comparator_off_o            <= CMP_OFF_RST;
      comparator_mux_select_o     <= CMP_SEL_RST;
      comparator_bandgap_enable_o <= CMP_SEL_RST;
    end else if (ce_i) begin
      comparator_off_o            <= next_cmp_off;
      comparator_mux_select_o     <= next_cmp_mux;
      comparator_bandgap_enable_o <= next_cmp_bg;
    end
  end

endmodule

// ==== sim/bsc_chk.sv ====
// Checker: port relations of the boundary-scan cells
`timescale 1ns/1ps
module bsc_chk #(
  parameter int NPIN = 8  // Port pins
) (
  input wire logic            mclk_i,    // Core clock
  input wire logic            resetn_i,  // Async reset
  input wire logic            ce_i,      // Core enable
  input wire logic [NPIN-1:0] port_output_latch_i,  // Latch
  input wire logic [NPIN-1:0] direction_bit_i,      // Direction
  input wire logic            pullup_disable_global_i,  // Off
  input wire logic [NPIN-1:0] alt_en_i,  // Alt owns pin
  input wire logic [NPIN-1:0] alt_oe_i,  // Alt enable
  input wire logic [NPIN-1:0] pad_i,     // Pin levels
  input wire logic [NPIN-1:0] pad_oe_o,  // Drive enable
  input wire logic [NPIN-1:0] pullup_en_o,        // Pull-ups
  input wire logic [NPIN-1:0] pin_input_value_o,  // Synced
  input wire logic [1:0]      twowire_buffer_enable_i,  // In
  input wire logic [1:0]      twowire_drive_en_o,       // Out
  input wire logic [4:0]      osc_enable_i,   // Functional
  input wire logic [4:0]      osc_enable_o,   // To clocks
  input wire logic            internal_cap_fuse_i,  // Fuse
  input wire logic            internal_cap_o,       // Caps
  input wire logic            comparator_off_i,     // Off in
  input wire logic            comparator_off_o,     // Off out
  input wire logic            tck_i,          // Test clock
  input wire logic            tap_capture_i,  // Capture
  input wire logic            tap_shift_i,    // Shift
  input wire logic            extest_i,       // Ext test
  input wire logic            instr_a_i,      // Preload
  input wire logic            tdo_o           // Serial out
);
  logic [3:0] fcnt;  // Settled cycles out of external test
  logic [3:0] ccnt;  // Settled cycles with core enabled
  wire  logic func_w = fcnt >= 4'h5;
  // ==========================================================
  // Helper counts: the mode sync needs a few cycles to clear
  // ==========================================================
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fcnt <= 4'h0;
      ccnt <= 4'h0;
    end else begin
      fcnt <= (ce_i && !extest_i) ? fcnt + {3'h0, fcnt < 4'h8} : 4'h0;
      ccnt <= ce_i ? ccnt + {3'h0, ccnt < 4'h8} : 4'h0;
    end
  end
  sequence no_strobe_s;
    !((extest_i | instr_a_i) & (tap_capture_i | tap_shift_i));
  endsequence
  // ==========================================================
  // Functional pass-through and scan hold
  // ==========================================================
  oe_func_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) func_w |-> pad_oe_o ==
    $past(alt_en_i & alt_oe_i | ~alt_en_i & direction_bit_i))
    else $error("pad enable not functional");
  pullup_func_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) func_w |-> pullup_en_o ==
    $past(~{NPIN{pullup_disable_global_i}} & ~direction_bit_i
          & port_output_latch_i)) else $error("pull-up term wrong");
  cmp_func_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) func_w |->
    comparator_off_o == $past(comparator_off_i)) else $error("cmp off");
  osc_func_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) func_w |->
    osc_enable_o == $past(osc_enable_i)) else $error("osc enable");
  tw_func_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) func_w |->
    twowire_drive_en_o == $past(twowire_buffer_enable_i))
    else $error("two-wire enable");
  cap_fuse_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) ccnt >= 4'h1 |->
    internal_cap_o == $past(internal_cap_fuse_i)) else $error("cap fuse");
  pin_sync_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) ccnt >= 4'h3 |->
    pin_input_value_o == $past(pad_i, 2)) else $error("pin sync delay");
  tdo_hold_a: assert property (
    @(posedge tck_i) disable iff (!resetn_i)
    no_strobe_s |=> $stable(tdo_o)) else $error("tdo moved, no strobe");
endmodule

// ==== sim/bsc_tap_model.sv ====
// Model of the external scan tester at the test access port
`timescale 1ns/1ps
module bsc_tap_model #(
  parameter int CL = 42  // Chain length
) (
  input  wire logic tdo_i,      // Chain serial out
  output logic      tck_o,      // Test clock, runs in frames and mode changes only
  output logic      tdi_o,      // Serial in
  output logic      capture_o,  // Capture-DR pulse
  output logic      shift_o,    // Shift-DR level
  output logic      update_o,   // Update-DR pulse
  output logic      extest_o,   // External test active
  output logic      preload_o   // Instr_a active
);
  // Idle levels: clock parked low, no instruction
  initial begin
    tck_o = 1'h0;
    tdi_o = 1'h0;
    capture_o = 1'h0;
    shift_o = 1'h0;
    update_o = 1'h0;
    extest_o = 1'h0;
    preload_o = 1'h0;
  end
  // One tck period; strobes only move while tck is low
  task automatic cyc();
    #7.5 tck_o = 1'h1;
    #7.5 tck_o = 1'h0;
  endtask
  task automatic mode(input logic ext, input logic pre);
    extest_o = ext;
    preload_o = pre;
    repeat (2) cyc();
  endtask
  // Frame: settle, capture, shift LSB first, update
  task automatic scan(input logic [CL-1:0] din,
                      output logic [CL-1:0] dout);
    repeat (2) cyc();  // Inputs steady before capture
    capture_o = 1'h1;
    cyc();
    capture_o = 1'h0;
    shift_o = 1'h1;
    for (int i = 0; i < CL; i++) begin
      dout[i] = tdo_i;
      tdi_o = din[i];
      cyc();
    end
    shift_o = 1'h0;
    tdi_o = ~tdi_o;  // Released line must not keep its last bit
    update_o = 1'h1;
    cyc();
    update_o = 1'h0;
    cyc();
  endtask
endmodule

// ==== sim/testbench.sv ====
// Testbench: scan frames and port checks for the boundary cells
`timescale 1ns/1ps
module testbench;
  import bsc_pkg::*;
  localparam int NPIN = 8;
  localparam int FB   = PIN_CELLS * NPIN;
  localparam int CL   = FB + FIX_CELLS;
  logic mclk_i = 1'h0, resetn_i = 1'h0, ce_i = 1'h1;
  logic [NPIN-1:0] port_output_latch_i = 8'h5a, direction_bit_i = 8'h0f;
  logic [NPIN-1:0] alt_en_i = '0, alt_out_i = '0, alt_oe_i = '0;
  logic [NPIN-1:0] pad_ext = 8'h35, pad_o, pad_oe_o, pullup_en_o;
  logic [NPIN-1:0] pin_input_value_o, od;
  logic pullup_disable_global_i = 1'h0, reset_pin_i = 1'h1;
  logic hv_reset_i = 1'h1, internal_cap_fuse_i = 1'h1;
  logic comparator_off_i = 1'h1, comparator_mux_select_i = 1'h0;
  logic comparator_bandgap_enable_i = 1'h0, comparator_out_i = 1'h0;
  logic [1:0] twowire_buffer_enable_i = 2'h2, twowire_drive_en_o;
  logic [4:0] osc_enable_i = 5'h01, osc_clock_i = 5'h1b, osc_enable_o;
  logic internal_cap_o, comparator_off_o, comparator_mux_select_o;
  logic comparator_bandgap_enable_o, tdo_o, tck_i, tdi_i, extest_i;
  logic tap_capture_i, tap_shift_i, tap_update_i, instr_a_i;
  logic [CL-1:0] din, dout;
  int failures = 0, checks = 0;
  // Pin wire: the device wins while it drives, else the board level
  wire logic [NPIN-1:0] pad_i = pad_oe_o & pad_o | ~pad_oe_o & pad_ext;
  always #10 mclk_i = ~mclk_i;
  bsc_top #(.NPIN(NPIN)) i_dut (.*);
  bsc_tap_model #(.CL(CL)) i_tap (.tdo_i(tdo_o), .tck_o(tck_i),
    .tdi_o(tdi_i), .capture_o(tap_capture_i), .shift_o(tap_shift_i),
    .update_o(tap_update_i), .extest_o(extest_i), .preload_o(instr_a_i));
  // ==========================================================
  // Compare, verdict and expected capture
  // ==========================================================
  task automatic check(input string name, input logic [CL-1:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [CL-1:0] cap_exp();
    logic [CL-1:0] v;
    v = '0;
    for (int p = 0; p < NPIN; p++) begin
      v[PIN_CELLS*p+PIN_PU] = ~pullup_disable_global_i
        & ~direction_bit_i[p] & port_output_latch_i[p];
      v[PIN_CELLS*p+PIN_OC] = alt_en_i[p] ? alt_oe_i[p] : direction_bit_i[p];
      v[PIN_CELLS*p+PIN_OD] = pad_i[p];
    end
    v[FB+OFS_TW +: TW_N] = twowire_buffer_enable_i;
    v[FB+OFS_RST_LV] = reset_pin_i;
    v[FB+OFS_RST_HV] = hv_reset_i;
    v[FB+OFS_OSC_EN +: OSC_N] = osc_enable_i;
    v[FB+OFS_OSC_CK +: OSC_N] = osc_enable_i & osc_clock_i
      | ~osc_enable_i & OSC_IDLE_LEVEL;
    v[FB+OFS_CMP_OFF] = comparator_off_i;
    v[FB+OFS_CMP_MUX] = comparator_mux_select_i;
    v[FB+OFS_CMP_BG] = comparator_bandgap_enable_i;
    v[FB+OFS_CMP_OUT] = comparator_out_i;
    return v;
  endfunction
  // Functional outputs after the sync and copy delays have passed
  task automatic fchk();
    repeat (8) @(negedge mclk_i);
    check("pad_oe", CL'(pad_oe_o), CL'(alt_en_i & alt_oe_i
      | ~alt_en_i & direction_bit_i));
    check("pad_o", CL'(pad_o), CL'(alt_en_i & alt_out_i
      | ~alt_en_i & port_output_latch_i));
    check("pullup", CL'(pullup_en_o), CL'(~{NPIN{pullup_disable_global_i}}
      & ~direction_bit_i & port_output_latch_i));
    check("pin_in", CL'(pin_input_value_o), CL'(pad_i));
    check("cmp", CL'({comparator_off_o, comparator_mux_select_o,
      comparator_bandgap_enable_o}), CL'(3'h4));
    check("osc", CL'(osc_enable_o), CL'(osc_enable_i));
    check("tw", CL'(twowire_drive_en_o), CL'(2'h2));
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    din = '0;
    din[PIN_OC] = 1'h1;
    din[PIN_OD] = 1'h1;
    din[PIN_CELLS+PIN_OC] = 1'h1;
    din[2*PIN_CELLS+PIN_OD] = 1'h1;
    din[3*PIN_CELLS+PIN_PU] = 1'h1;
    din[FB+OFS_CMP_MUX] = 1'h1;
    din[FB+OFS_CMP_BG] = 1'h1;
    din[FB+OFS_OSC_EN+OSC_CRYSTAL] = 1'h1;
    repeat (2) @(negedge mclk_i);
    check("reset", CL'({pad_oe_o, comparator_off_o, tdo_o}),
      CL'(2'h2));
    resetn_i = 1'h1;
    fchk();
    alt_en_i = 8'h03;
    alt_out_i = 8'h01;
    alt_oe_i = 8'h01;
    pullup_disable_global_i = 1'h1;
    fchk();
    i_tap.mode(1'h0, 1'h1);
    i_tap.scan(din, dout);
    check("capture", dout,
      cap_exp());
    fchk();
    i_tap.mode(1'h1, 1'h0);
    repeat (8) @(negedge mclk_i);
    check("x_oe", CL'(pad_oe_o), CL'(8'h03));
    check("x_pad", CL'(pad_o & pad_oe_o), CL'(8'h01));
    check("x_pu", CL'(pullup_en_o), CL'(8'h08));
    check("x_cmp", CL'({comparator_off_o, comparator_mux_select_o,
      comparator_bandgap_enable_o}), CL'(3'h3));
    check("x_osc", CL'(osc_enable_o), CL'(5'h02));
    check("x_tw", CL'(twowire_drive_en_o), CL'(2'h0));
    check("x_cap", CL'(internal_cap_o), CL'(1'h1));
    i_tap.scan(din, dout);
    for (int p = 0; p < NPIN; p++) begin
      od[p] = dout[PIN_CELLS*p+PIN_OD];
    end
    check("x_capture", CL'(od), CL'({pad_ext[7:2], 2'h1}));
    i_tap.mode(1'h0, 1'h0);
    fchk();
    stop_test();
  end
  // Watchdog far beyond the few frames the sequence needs
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
bind bsc_top bsc_chk #(.NPIN(NPIN)) u_chk (.*);
